// *** hw/cpbc_policy.sv ***
// Cache policy decisions, eviction control and hold acknowledge gating
//
// Added by the designer: the shared constants.
`timescale 1ns/1ps
`include "cpbc_map.svh"
module cpbc_policy (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // Processor bus cycle start
  input  wire logic                cacheSelectN,
  input  wire logic                cpu_addr_strobe_n,
  input  wire logic                snoop_addr_strobe_n,
  input  wire logic                cpuWrite,
  input  wire logic                lockN,
  input  wire cpbc_pkg::cpbc_idx_t lineIndex,
  input  wire logic                tagHit,
  input  wire logic                snoopHit,
  // Page write-through pin
  input  wire logic                page_write_through_in,
  output logic                     page_write_through_out,
  output logic                     page_write_through_oe,
  // System bus
  input  wire logic                system_cacheable_n,
  input  wire logic                system_write_policy,
  input  wire logic                wordReady,
  input  wire logic                lastWord,
  input  wire logic                evictDone,
  output logic                     system_backoff_n,
  output logic                     cache_backoff_out_n,
  // Processor side hold acknowledge input and outputs
  input  wire logic                cpu_hold_ack_in,
  output logic                     cache_hold_ack_out,
  output logic                     dirty_line_access_n,
  output logic                     cache_write_policy_out,
  output logic                     writeAllocOn
);
  import cpbc_pkg::*;

  // Control state
  cpbc_state_e state_reg, state_next;
  cpbc_state_e after_reg, after_next;   // State to enter when eviction ends
  cpbc_idx_t   idx_reg, idx_next;       // Line of the running cycle
  logic        selPrevN_reg;            // Select seen one clock earlier
  logic        skenPrev_reg;            // Cacheable input one clock earlier
  logic        pwt_reg, pwt_next;       // Page write-through at cycle start
  logic        cur_dirty_reg, cur_dirty_next;
  logic        first_reg, first_next;   // Next word is the first of the line
  logic        fill_ok_reg, fill_ok_next;
  logic        fill_wt_reg, fill_wt_next;
  logic        noncache_reg, noncache_next;
  logic        resetSeen_reg;           // First edge after release passed
  logic        alloc_reg;
  // Output flops
  logic        dirtyN_reg, dirtyN_next;
  logic        policy_reg, policy_next;
  logic        sboffN_reg, sboffN_next;
  logic        cpu_hold_ack_in_reg, cpu_hold_ack_in_next;
  logic        pwtOe_reg;               // Page pin driven, own flop so the pin is glitch free
  // Flag store
  logic        lnValid, lnDirty, lnWb;
  logic        fWrEn, fValid, fDirty, fWb;
  cpbc_idx_t   fIdx;
  // Decode
  logic        selOk, cpuStart, snoopStart, isHit, forceWt;

  // Both select samples low before any cycle is taken [RQ14]
  assign selOk      = !cacheSelectN && !selPrevN_reg;
  assign cpuStart   = selOk && !cpu_addr_strobe_n && state_reg == ST_IDLE;
  assign snoopStart = selOk && !snoop_addr_strobe_n && cpu_addr_strobe_n &&
                      state_reg == ST_IDLE;
  assign isHit      = tagHit && lnValid;
  // Write-through forced by page or lock at cycle start [RQ6] [RQ13]
  assign forceWt    = page_write_through_in || !lockN;

  cpbc_line_flags #(
    .LINES(`CPBC_LINES)
  ) u_flags (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .rdIdx      (lineIndex),
    .rdValid    (lnValid),
    .rdDirty    (lnDirty),
    .rdWriteBack(lnWb),
    .wrEn       (fWrEn),
    .wrIdx      (fIdx),
    .wrValid    (fValid),
    .wrDirty    (fDirty),
    .wrWriteBack(fWb)
  );

  // Cycle sequencing and flag updates
  always_comb begin
    state_next     = state_reg;
    after_next     = after_reg;
    idx_next       = idx_reg;
    pwt_next       = pwt_reg;
    cur_dirty_next = cur_dirty_reg;
    first_next     = first_reg;
    fill_ok_next   = fill_ok_reg;
    fill_wt_next   = fill_wt_reg;
    noncache_next  = noncache_reg;
    fWrEn          = 1'b0;
    fIdx           = idx_reg;
    fValid         = 1'b1;
    fDirty         = 1'b0;
    fWb            = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (cpuStart) begin
          idx_next       = lineIndex;
          pwt_next       = page_write_through_in;  // [RQ5]
          cur_dirty_next = lnDirty;
          first_next     = 1'b1;
          fill_ok_next   = 1'b0;
          noncache_next  = !lockN;                 // [RQ11]
          if (!cpuWrite) begin
            if (!lockN && lnDirty) begin
              // Locked read on dirty data: evict first [RQ12]
              state_next = ST_EVICT;
              after_next = ST_READ;
            end else if (!isHit || !lockN) begin
              state_next = ST_READ;                // Miss or locked [RQ11]
            end
          end else if (isHit && lnWb && !forceWt) begin
            // Write-back hit stays local and dirties the line
            fWrEn  = 1'b1;
            fIdx   = lineIndex;
            fDirty = 1'b1;
            fWb    = 1'b1;
          end else begin
            state_next = ST_WRITE;                 // [RQ6] [RQ13]
          end
        end else if (snoopStart && snoopHit && lnValid && lnDirty) begin
          // Snoop hit on dirty data: supply it
          idx_next       = lineIndex;
          cur_dirty_next = 1'b0;
          state_next     = ST_EVICT;
          after_next     = ST_IDLE;
        end
      end
      ST_READ: begin
        if (wordReady) begin
          first_next = 1'b0;
          if (first_reg) begin
            // Cacheable must be low a clock before the first word [RQ2] [RQ3]
            fill_ok_next = !skenPrev_reg && !noncache_reg;
            // Page write-through wins over the system policy [RQ5] [RQ15]
            fill_wt_next = pwt_reg || !system_write_policy;
          end
          if (lastWord) begin
            state_next = ST_IDLE;
            if (first_reg ? (!skenPrev_reg && !noncache_reg) : fill_ok_reg) begin
              fWrEn = 1'b1;                        // [RQ2] [RQ16]
              fWb   = first_reg ? !(pwt_reg || !system_write_policy) : !fill_wt_reg;
            end
          end
        end
      end
      ST_WRITE: begin
        // Write-through cycle served by the system
        if (wordReady && lastWord) begin
          state_next = ST_IDLE;
        end
      end
      ST_EVICT: begin
        if (evictDone) begin
          // Line now matches memory; keep its policy as clean write-back
          fWrEn      = 1'b1;
          fWb        = 1'b1;
          state_next = after_reg;
        end
      end
    endcase
  end

  // Output decisions, all registered [RQ17]
  always_comb begin
    // Dirty line seen on memory cycle, hit or miss [RQ1]
    if (cpuStart) begin
      dirtyN_next = !lnDirty;
    end else if (state_next == ST_IDLE || state_reg == ST_IDLE) begin
      dirtyN_next = 1'b1;
    end else begin
      dirtyN_next = !cur_dirty_reg;
    end
    // System write-through forces policy output low
    if (!system_write_policy) begin
      policy_next = 1'b0;
    end else if (cpuStart && isHit) begin
      policy_next = lnWb && !forceWt;
    end else begin
      policy_next = policy_reg;
    end
    // Back-off held for the whole eviction [RQ7]
    sboffN_next = state_next != ST_EVICT;
    // Hold acknowledge delayed one clock, blocked while evicting [RQ8] [RQ9] [RQ10]
    cpu_hold_ack_in_next = cpu_hold_ack_in && state_next != ST_EVICT;
  end

  // Registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      after_reg     <= ST_IDLE;
      idx_reg       <= '0;
      selPrevN_reg  <= 1'b1;
      skenPrev_reg  <= 1'b1;
      pwt_reg       <= 1'b0;
      cur_dirty_reg <= 1'b0;
      first_reg     <= 1'b0;
      fill_ok_reg   <= 1'b0;
      fill_wt_reg   <= 1'b0;
      noncache_reg  <= 1'b0;
      dirtyN_reg    <= 1'b1;
      policy_reg    <= 1'b0;
      sboffN_reg    <= 1'b1;
      cpu_hold_ack_in_reg      <= 1'b0;
      pwtOe_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      after_reg     <= after_next;
      idx_reg       <= idx_next;
      selPrevN_reg  <= cacheSelectN;
      skenPrev_reg  <= system_cacheable_n;
      pwt_reg       <= pwt_next;
      cur_dirty_reg <= cur_dirty_next;
      first_reg     <= first_next;
      fill_ok_reg   <= fill_ok_next;
      fill_wt_reg   <= fill_wt_next;
      noncache_reg  <= noncache_next;
      dirtyN_reg    <= dirtyN_next;
      policy_reg    <= policy_next;
      sboffN_reg    <= sboffN_next;
      cpu_hold_ack_in_reg      <= cpu_hold_ack_in_next;
      pwtOe_reg     <= !sboffN_next;       // Same edge as back-off [RQ7]
    end
  end

  // Write allocation strap, caught at the first edge after release,
  // since an async reset may only load constants [RQ4]
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resetSeen_reg <= 1'b0;
      alloc_reg     <= 1'b0;
    end else begin
      resetSeen_reg <= 1'b1;
      if (!resetSeen_reg) begin
        alloc_reg <= !system_cacheable_n;          // [RQ4]
      end
    end
  end

  assign dirty_line_access_n    = dirtyN_reg;
  assign cache_write_policy_out = policy_reg;
  assign system_backoff_n       = sboffN_reg;
  assign cache_backoff_out_n    = sboffN_reg;
  assign page_write_through_oe  = pwtOe_reg;       // [RQ7]
  assign page_write_through_out = 1'b0;
  assign cache_hold_ack_out     = cpu_hold_ack_in_reg;
  assign writeAllocOn           = alloc_reg;

  // Checks
  holdack_delay_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ8]
    state_reg != ST_EVICT |-> cache_hold_ack_out == $past(cpu_hold_ack_in))
    else $error("hold ack not one clock after input");
  holdack_block_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ9]
    state_reg == ST_EVICT |-> !cache_hold_ack_out)
    else $error("hold ack seen during write-back");
  evict_pins_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ7]
    state_reg == ST_EVICT |-> !system_backoff_n && page_write_through_oe &&
                              !page_write_through_out)
    else $error("eviction without back-off or page pin low");
  backoff_release_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ10]
    $rose(system_backoff_n) |-> $past(state_reg) == ST_EVICT && !$past(system_backoff_n))
    else $error("back-off released outside eviction");
  dirty_access_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ1]
    cpuStart && lnDirty |=> !dirty_line_access_n)
    else $error("dirty line access not flagged");
  select_guard_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ14]
    state_reg == ST_IDLE && (cacheSelectN || selPrevN_reg) |=> state_reg == ST_IDLE)
    else $error("cycle taken without two select samples");
  lock_evict_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ12]
    cpuStart && !cpuWrite && !lockN && lnDirty |=> state_reg == ST_EVICT ##0
    after_reg == ST_READ)
    else $error("locked dirty read did not evict");
  force_wt_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ6] [RQ13]
    cpuStart && cpuWrite && forceWt |=> state_reg == ST_WRITE)
    else $error("forced write-through not passed to system");
  fill_gate_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ2] [RQ3]
    state_reg == ST_READ && wordReady && first_reg && skenPrev_reg && !lastWord
    |=> !fill_ok_reg)
    else $error("fill allowed without early cacheable");
  policy_force_a: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ15]
    !system_write_policy |=> !cache_write_policy_out)
    else $error("policy output not forced low");
endmodule

// *** hw/cpbc_map.svh ***
// Constants for the cache policy and bus control block
// Operation
// RQ1: Assert dirty-line output on dirty memory access
// RQ2: Fill read miss only when cacheable
// RQ3: System gives cacheable low cycle before word
// RQ4: Cacheable level at reset sets write allocation
// RQ5: Page write-through on read miss marks line
// RQ6: Page write-through forces write-through on writes
// RQ7: Drive page write-through low during evictions
// RQ8: Hold acknowledge follows input one cycle later
// RQ9: Hold acknowledge blocked during write-back
// RQ10: Hold acknowledge allowed after back-off release
// RQ11: Locked clean read is non-cacheable miss
// RQ12: Locked dirty read evicts, then non-cacheable miss
// RQ13: Locked write ignores flag, goes write-through
// RQ14: Respond only with select low two clocks
// RQ15: Fill policy from system policy at first word
// RQ16: Keep dirty and policy flag per line
// RQ17: Sample inputs and drive outputs on clock
`ifndef CPBC_MAP_SVH
`define CPBC_MAP_SVH
`define CPBC_LINES   256
`define CPBC_IDX_W   8
`define CPBC_ST_IDLE  4'h1
`define CPBC_ST_READ  4'h2
`define CPBC_ST_WRITE 4'h4
`define CPBC_ST_EVICT 4'h8
`endif

// *** hw/cpbc_pkg.sv ***
// Types shared by the cache policy and bus control block
`include "cpbc_map.svh"
package cpbc_pkg;
  // One-hot control states
  typedef enum logic [3:0] {
    ST_IDLE  = `CPBC_ST_IDLE,
    ST_READ  = `CPBC_ST_READ,
    ST_WRITE = `CPBC_ST_WRITE,
    ST_EVICT = `CPBC_ST_EVICT
  } cpbc_state_e;
  typedef logic [`CPBC_IDX_W-1:0] cpbc_idx_t;
endpackage

// *** hw/cpbc_line_flags.sv ***
// Per-line valid, dirty and write-back flag store
`timescale 1ns/1ps
`include "cpbc_map.svh"
module cpbc_line_flags #(
  parameter int LINES = `CPBC_LINES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Read port
  input  wire cpbc_pkg::cpbc_idx_t rdIdx,
  output logic                   rdValid,
  output logic                   rdDirty,
  output logic                   rdWriteBack,
  // Write port
  input  wire logic              wrEn,
  input  wire cpbc_pkg::cpbc_idx_t wrIdx,
  input  wire logic              wrValid,
  input  wire logic              wrDirty,
  input  wire logic              wrWriteBack
);
  import cpbc_pkg::*;

  logic [LINES-1:0] valid_reg;    // Line holds data
  logic [LINES-1:0] dirty_reg;    // Line newer than memory
  logic [LINES-1:0] wb_reg;       // Line is write-back
  logic [LINES-1:0] valid_next;
  logic [LINES-1:0] dirty_next;
  logic [LINES-1:0] wb_next;

  // Lookup is combinational so policy is decided in the strobe cycle
  assign rdValid     = valid_reg[rdIdx];
  assign rdDirty     = dirty_reg[rdIdx];
  assign rdWriteBack = wb_reg[rdIdx];

  // Next flags: one line updated per cycle [RQ16]
  always_comb begin
    valid_next = valid_reg;
    dirty_next = dirty_reg;
    wb_next    = wb_reg;
    if (wrEn) begin
      valid_next[wrIdx] = wrValid;
      dirty_next[wrIdx] = wrDirty;
      wb_next[wrIdx]    = wrWriteBack;
    end
  end

  // Flags cleared at reset; data SRAM contents are meaningless then
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      valid_reg <= '0;
      dirty_reg <= '0;
      wb_reg    <= '0;
    end else begin
      valid_reg <= valid_next;
      dirty_reg <= dirty_next;
      wb_reg    <= wb_next;
    end
  end
endmodule

// *** dv/cpbc_sys_model.sv ***
// System bus model: line fills, single-word write completion and evictions
`timescale 1ns/1ps
module cpbc_sys_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Requests from the bench
  input  wire logic       fillReq,
  input  wire logic [2:0] fillLen,
  input  wire logic [2:0] fillGap,
  input  wire logic       fillCach,
  input  wire logic       fillWb,
  input  wire logic       strapN,
  // System bus pins
  input  wire logic       system_backoff_n,
  output logic            system_cacheable_n,
  output logic            system_write_policy,
  output logic            wordReady,
  output logic            lastWord,
  output logic            evictDone
);
  logic [2:0] gapReg;   // Wait cycles before the first word
  logic [2:0] leftReg;  // Words still to send
  logic [2:0] evCntReg; // Cycles spent in an eviction
  // One process; policy idles high, cacheable at the strap level until the first fill and high after it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      system_cacheable_n  <= strapN; // Strap held through first edge
      system_write_policy <= 1'b1;
      {wordReady, lastWord, evictDone} <= 3'h0;
      {gapReg, leftReg, evCntReg} <= 9'h000;
    end else begin
      {wordReady, lastWord, evictDone} <= 3'h0;
      // Policy pin back to its pulled-up level once the last word has been taken
      if (lastWord) begin
        system_write_policy <= 1'b1;
      end
      if (fillReq) begin
        // Level set at least a cycle before the first word
        system_cacheable_n  <= !fillCach;
        system_write_policy <= fillWb;
        gapReg              <= fillGap;
        leftReg             <= fillLen;
      end else if (leftReg != 3'h0) begin
        if (gapReg != 3'h0) begin
          gapReg <= gapReg - 3'h1;
        end else begin
          wordReady <= 1'b1;
          lastWord  <= (leftReg == 3'h1);
          leftReg   <= leftReg - 3'h1;
          // Back to the pulled-up level as the last word is driven
          if (leftReg == 3'h1) begin
            system_cacheable_n <= 1'b1;
          end
        end
      end
      // Slow memory: accept the write-back a few cycles later
      if (!system_backoff_n && !evictDone) begin
        evCntReg  <= (evCntReg == 3'h3) ? 3'h0 : evCntReg + 3'h1;
        evictDone <= (evCntReg == 3'h3);
      end else begin
        evCntReg <= 3'h0;
      end
    end
  end
endmodule

// *** dv/cache_policy_bus_control_tb.sv ***
// Self-checking bench for the cache policy block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module cache_policy_bus_control_tb;
  import cpbc_pkg::*;
  logic mclk, arst_n, strobeN, cpuWrite, lockN, tagHit, pwtDrv, holdIn, strapN;
  logic fillReq, fillCach, fillWb, cach, wb, wr, rdy, last, evDone, d, ev;
  logic [2:0] fillLen, fillGap;
  logic selN, snoopN, snHit;
  cpbc_idx_t lineIndex;
  logic pwtOut, pwtOe, sysBoN, cBoN, holdOut, dirtyN, polOut, allocOn;
  wire  pwtWire = pwtOe ? pwtOut : pwtDrv; // Shared pin level
  int error_cnt, tests_run;
  // Device under test
  cpbc_policy i_dut (.mclk(mclk), .arst_n(arst_n), .cacheSelectN(selN),
    .cpu_addr_strobe_n(strobeN), .snoop_addr_strobe_n(snoopN), .cpuWrite(cpuWrite),
    .lockN(lockN), .lineIndex(lineIndex), .tagHit(tagHit), .snoopHit(snHit),
    .page_write_through_in(pwtWire), .page_write_through_out(pwtOut),
    .page_write_through_oe(pwtOe), .system_cacheable_n(cach),
    .system_write_policy(wb), .wordReady(rdy), .lastWord(last), .evictDone(evDone),
    .system_backoff_n(sysBoN), .cache_backoff_out_n(cBoN), .cpu_hold_ack_in(holdIn),
    .cache_hold_ack_out(holdOut), .dirty_line_access_n(dirtyN),
    .cache_write_policy_out(polOut), .writeAllocOn(allocOn));
  // Far side of the system bus
  cpbc_sys_model i_sys (.mclk(mclk), .arst_n(arst_n), .fillReq(fillReq),
    .fillLen(fillLen), .fillGap(fillGap), .fillCach(fillCach), .fillWb(fillWb),
    .strapN(strapN), .system_backoff_n(sysBoN), .system_cacheable_n(cach),
    .system_write_policy(wb), .wordReady(rdy), .lastWord(last), .evictDone(evDone));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset with a given strap level, then check the allocation result
  task automatic rst(input logic strap);
    strapN <= strap;
    arst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1 `CHK("walloc", !strap, allocOn)
    @(posedge mclk);
  endtask
  // One processor cycle; optional system data of len words
  task automatic cyc(input logic w, lk, page_write_through, hit, input cpbc_idx_t idx,
                     input logic [2:0] len, input logic c, p, output logic ds);
    int n;
    n  = 0;
    ev = 1'b0;
    @(posedge mclk);
    strobeN <= 1'b0; cpuWrite <= w; lockN <= lk; pwtDrv <= page_write_through;
    tagHit <= hit; lineIndex <= idx;
    @(posedge mclk);
    strobeN <= 1'b1;
    #1 ds = dirtyN;
    @(posedge mclk);
    #1 ds = ds & dirtyN;
    // Eviction phase: pin driven low, acknowledge blocked
    while (!sysBoN && n < 40) begin
      ev = 1'b1;
      `CHK("pwt_oe", 1'b1, pwtOe)
      `CHK("pwt_lvl", 1'b0, pwtWire)
      `CHK("hold_blk", 1'b0, holdOut)
      `CHK("cache_backoff_out_n", 1'b0, cBoN)
      @(posedge mclk);
      #1 n++;
    end
    if (ev) begin
      @(posedge mclk);
      #1 `CHK("hold_back", holdIn, holdOut)
    end
    if (len != 3'h0) begin
      @(posedge mclk);
      fillReq <= 1'b1; fillLen <= len; fillGap <= {1'b0, idx[1:0]};
      fillCach <= c; fillWb <= p;
      @(posedge mclk);
      fillReq <= 1'b0;
      do begin
        @(posedge mclk);
        #1 n++;
      end while (!(rdy && last) && n < 40);
      @(posedge mclk);
      #1;
    end
    if (n >= 40) begin
      `CHK("cycle_end", 1'b1, 1'b0)
    end
  endtask
  // Main sequence
  initial begin
    logic [5:0] pat;
    error_cnt = 0; tests_run = 0; pat = 6'h2D;
    arst_n = 1'b0; strapN = 1'b1; strobeN = 1'b1; cpuWrite = 1'b0; lockN = 1'b1;
    tagHit = 1'b0; pwtDrv = 1'b0; holdIn = 1'b0; lineIndex = '0; fillReq = 1'b0;
    fillLen = 3'h0; fillGap = 3'h0; fillCach = 1'b0; fillWb = 1'b0;
    selN = 1'b0; snoopN = 1'b1; snHit = 1'b0; // Select low from the start
    rst(1'b1);
    rst(1'b0);
    // Hold acknowledge follows one cycle later
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      holdIn <= pat[i];
      #1 if (i > 0) `CHK("hold_dly", pat[i-1], holdOut)
    end
    // Fills: write-back, page write-through, non-cacheable, system write-through
    cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h05, 3'h4, 1'b1, 1'b1, d);
    `CHK("dirty_fill", 1'b1, d)
    cyc(1'b0, 1'b1, 1'b1, 1'b0, 8'h06, 3'h4, 1'b1, 1'b1, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h07, 3'h4, 1'b0, 1'b1, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 3'h2, 1'b1, 1'b0, d);
    `CHK("pol_sys", 1'b0, polOut)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("pol_wb", 1'b1, polOut)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h06, 3'h0, 1'b0, 1'b0, d);
    `CHK("pol_pwt", 1'b0, polOut)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h08, 3'h0, 1'b0, 1'b0, d);
    `CHK("pol_swt", 1'b0, polOut)
    // A write to the uncached line must not find a write-back line
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 8'h07, 3'h1, 1'b0, 1'b0, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h07, 3'h1, 1'b0, 1'b0, d);
    `CHK("no_fill", 1'b1, d)
    // Write-back hit dirties the line; a miss still reports it
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    cyc(1'b1, 1'b1, 1'b0, 1'b0, 8'h05, 3'h1, 1'b0, 1'b0, d);
    `CHK("dirty_miss", 1'b0, d)
    // Locked read of a dirty line: evict, then uncached read
    cyc(1'b0, 1'b0, 1'b0, 1'b1, 8'h05, 3'h4, 1'b1, 1'b1, d);
    `CHK("dirty_lock", 1'b0, d)
    `CHK("evicted", 1'b1, ev)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("clean_aft", 1'b1, d)
    // Forced write-through writes leave the line clean
    cyc(1'b1, 1'b1, 1'b1, 1'b1, 8'h05, 3'h1, 1'b0, 1'b0, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("pwt_write", 1'b1, d)
    cyc(1'b1, 1'b0, 1'b0, 1'b1, 8'h05, 3'h1, 1'b0, 1'b0, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("lock_write", 1'b1, d)
    // Locked read of a clean line: no eviction, waits for data
    cyc(1'b0, 1'b0, 1'b0, 1'b1, 8'h06, 3'h4, 1'b1, 1'b1, d);
    `CHK("lock_clean", 1'b0, ev)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h06, 3'h0, 1'b0, 1'b0, d);
    `CHK("lock_nc", 1'b0, polOut)
    // Dirty the line, then strobe it without two select samples
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    @(posedge mclk);
    selN <= 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("desel", 1'b1, d)
    fork
      cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
      begin
        @(posedge mclk);
        selN <= 1'b0; // Low from the strobe cycle on, one select sample short
      end
    join
    `CHK("sel_once", 1'b1, d)
    // Snoop hit on the dirty line: supplied under back-off, page pin low
    @(posedge mclk);
    snoopN <= 1'b0; snHit <= 1'b1; lineIndex <= 8'h05; pwtDrv <= 1'b1;
    @(posedge mclk);
    snoopN <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK("snp_bo", 1'b0, sysBoN)
    `CHK("snp_pwt", 1'b0, pwtWire)
    `CHK("snp_hold", 1'b0, holdOut)
    repeat (4) @(posedge mclk);
    #1 `CHK("snp_end", 1'b1, sysBoN)
    cyc(1'b0, 1'b1, 1'b0, 1'b1, 8'h05, 3'h0, 1'b0, 1'b0, d);
    `CHK("snp_clean", 1'b1, d)
    finish_test;
  end
  // Watchdog against a hung cycle
  initial begin
    #60000;
    error_cnt++;
    finish_test;
  end
endmodule
